// >>> src/tsrl_latch.sv
`timescale 1ns/1ps
// Contract
// - idle set/reset: rising trigger edge inverts output
// - set alone forces output high
// - reset alone forces output low
// - no inputs, no edge: output holds
// - reset-first mode: both active gives 0
// - set-first mode: both active gives 1
// - two precedence modes, reset-first by default

module tsrl_latch
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // pins
    input  wire logic                 toggle_trigger,
    input  wire logic                 set_in,
    input  wire logic                 reset_in,
    // configuration, steady strap
    input  wire tsrl_pkg::tsrl_prec_t precedence_select,
    // result
    output logic                      out_bit
);
    import tsrl_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic                    trg_s;
    logic                    set_s;
    logic                    rst_s;
    logic [TSRL_PIN_CNT-1:0] pins;
    logic [TSRL_PIN_CNT-1:0] pins_s;

    assign pins  = {toggle_trigger, set_in, reset_in};
    assign trg_s = pins_s[TSRL_PIN_TRG];
    assign set_s = pins_s[TSRL_PIN_SET];
    assign rst_s = pins_s[TSRL_PIN_RST];

    // one synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < TSRL_PIN_CNT; gi++)
        begin : g_sync
            tsrl_sync u_sync
            (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .pin_in  (pins[gi]),
                .level   (pins_s[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // precedence strap capture
    // ----------------------------------------
    tsrl_prec_t prec;
    tsrl_prec_t next_prec;

    // follows the strap after reset release
    always_comb
    begin
        next_prec = precedence_select;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            prec <= TSRL_PREC_DEFAULT;
        else
            prec <= next_prec;
    end

    // ----------------------------------------
    // output state
    // ----------------------------------------
    logic trg_prev;
    logic next_trg_prev;
    logic next_out;
    logic trg_rise;

    assign trg_rise = trg_s & ~trg_prev;

    // next output from set, reset, precedence and edge
    always_comb
    begin
        next_trg_prev = trg_s;
        next_out      = out_bit;
        case ({set_s, rst_s})
            2'b00:   next_out = trg_rise ? ~out_bit : out_bit;
            2'b01:   next_out = 1'b0;
            2'b10:   next_out = 1'b1;
            2'b11:   next_out = (prec == TSRL_SET_FIRST);
            default: next_out = out_bit;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_bit  <= TSRL_OUT_RST;
            trg_prev <= 1'b0;
        end
        else
        begin
            out_bit  <= next_out;
            trg_prev <= next_trg_prev;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // toggle check
    toggle_inverts_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!set_s && !rst_s && trg_rise) |=> (out_bit != $past(out_bit)))
        else $error("edge did not invert output");

    set_forces_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (set_s && !rst_s) |=> out_bit)
        else $error("set did not force high");

    reset_forces_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!set_s && rst_s) |=> !out_bit)
        else $error("reset did not force low");

    idle_holds_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!set_s && !rst_s && !trg_rise) |=> $stable(out_bit))
        else $error("output changed while idle");

    both_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (set_s && rst_s && prec == TSRL_RESET_FIRST) |=> !out_bit)
        else $error("reset-first gave high");

    both_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (set_s && rst_s && prec == TSRL_SET_FIRST) |=> out_bit)
        else $error("set-first gave low");

    prec_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> (prec == $past(precedence_select)))
        else $error("precedence not captured");

    edge_history_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> (trg_prev == $past(trg_s)))
        else $error("trigger history wrong");

    held_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!set_s && !rst_s && trg_s && trg_prev)[*2] |-> $stable(out_bit))
        else $error("held trigger toggled again");

    // ----------------------------------------
    // reset state and pin to output paths
    // ----------------------------------------
    // pins take five edges to reach out_bit
    // windows cover that whole pipeline

    reset_state_a: assert property (@(posedge ref_clk)
        !rst_n |=> (out_bit == TSRL_OUT_RST && prec == TSRL_PREC_DEFAULT && !trg_prev))
        else $error("reset state wrong");

    change_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(out_bit) |-> $past(set_s || rst_s || trg_rise))
        else $error("output changed without cause");

    trg_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((toggle_trigger)[*5] |-> trg_s) and ((!toggle_trigger)[*5] |-> !trg_s))
        else $error("trigger sample lags pin");

    set_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (set_in && !reset_in)[*6] |-> out_bit)
        else $error("set pin did not raise output");

    reset_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reset_in && !set_in)[*6] |-> !out_bit)
        else $error("reset pin did not clear output");

    rfirst_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (set_in && reset_in && precedence_select == TSRL_RESET_FIRST)[*6] |-> !out_bit)
        else $error("reset-first pins gave high");

    sfirst_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (set_in && reset_in && precedence_select == TSRL_SET_FIRST)[*6] |-> out_bit)
        else $error("set-first pins gave low");

    toggle_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!set_in && !reset_in && !toggle_trigger)[*4]
        ##1 (!set_in && !reset_in && toggle_trigger)[*6]
        |-> (out_bit != $past(out_bit)))
        else $error("pin edge did not toggle output");

    hold_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!set_in && !reset_in && !toggle_trigger)[*8] |-> $stable(out_bit))
        else $error("quiet pins changed output");

endmodule // tsrl_latch

// >>> src/tsrl_pkg.sv
package tsrl_pkg;

    // ----------------------------------------
    // precedence modes
    // ----------------------------------------
    typedef enum logic
    {
        TSRL_RESET_FIRST = 1'b0,
        TSRL_SET_FIRST   = 1'b1
    } tsrl_prec_t;

    // power-up default: reset wins
    localparam tsrl_prec_t TSRL_PREC_DEFAULT = TSRL_RESET_FIRST;

    // ----------------------------------------
    // reset values and synchroniser depth
    // ----------------------------------------
    localparam logic       TSRL_OUT_RST  = 1'b0;
    localparam logic [2:0] TSRL_SYNC_RST = 3'h0;
    localparam int         TSRL_SYNC_LEN = 3;

    // ----------------------------------------
    // pin bundle positions
    // ----------------------------------------
    localparam int         TSRL_PIN_CNT  = 3;
    localparam int         TSRL_PIN_TRG  = 2;
    localparam int         TSRL_PIN_SET  = 1;
    localparam int         TSRL_PIN_RST  = 0;

endpackage

// >>> src/tsrl_sync.sv
`timescale 1ns/1ps

// ----------------------------------------
// three-stage input synchroniser
// ----------------------------------------
module tsrl_sync
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // pin side
    input  wire logic pin_in,
    // clocked side
    output logic      level
);
    import tsrl_pkg::*;

    logic [TSRL_SYNC_LEN-1:0] stage;
    logic [TSRL_SYNC_LEN-1:0] next_stage;
    logic                     next_level;

    // shift in; level changes when stages 2 and 3 agree
    always_comb
    begin
        next_stage = {stage[TSRL_SYNC_LEN-2:0], pin_in};
        next_level = level;
        if (stage[TSRL_SYNC_LEN-2] == stage[TSRL_SYNC_LEN-1])
        begin
            next_level = stage[TSRL_SYNC_LEN-1];
        end
    end

    // registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage <= TSRL_SYNC_RST;
            level <= TSRL_SYNC_RST[TSRL_SYNC_LEN-1];
        end
        else
        begin
            stage <= next_stage;
            level <= next_level;
        end
    end

endmodule // tsrl_sync

// >>> tb/toggle_set_reset_latch_bench.sv
`timescale 1ns/1ps

module toggle_set_reset_latch_bench;
    import tsrl_pkg::*;

    // ----------------------------------------
    // signals and counters
    // ----------------------------------------
    logic       ref_clk;
    logic       rst_n;
    logic       toggle_trigger;
    logic       set_in;
    logic       reset_in;
    tsrl_prec_t precedence_select;
    logic       out_bit;
    int         n_errors;
    int         check_count;

    tsrl_latch dut
    (
        .ref_clk           (ref_clk),
        .rst_n             (rst_n),
        .toggle_trigger    (toggle_trigger),
        .set_in            (set_in),
        .reset_in          (reset_in),
        .precedence_select (precedence_select),
        .out_bit           (out_bit)
    );

    // free-running clock, 5 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: out_bit %b, expected %b", $time, got, exp);
        end
    endtask

    // drive pins, then wait past the 5 to 6 edge latency
    task automatic drive(input logic t, input logic s, input logic r);
        toggle_trigger = t;
        set_in         = s;
        reset_in       = r;
        repeat (8) @(negedge ref_clk);
    endtask

    task automatic summarize();
        $display("checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_toggle();
        drive(1'b0, 1'b0, 1'b0);
        check(out_bit, 1'b0);
        drive(1'b1, 1'b0, 1'b0);
        check(out_bit, 1'b1);
        drive(1'b1, 1'b0, 1'b0);
        check(out_bit, 1'b1);
        drive(1'b0, 1'b0, 1'b0);
        check(out_bit, 1'b1);
        drive(1'b1, 1'b0, 1'b0);
        check(out_bit, 1'b0);
        drive(1'b0, 1'b0, 1'b0);
        $display("test toggle done");
    endtask

    task automatic t_force();
        drive(1'b0, 1'b1, 1'b0);
        check(out_bit, 1'b1);
        drive(1'b1, 1'b1, 1'b0);
        check(out_bit, 1'b1);
        drive(1'b0, 1'b0, 1'b1);
        check(out_bit, 1'b0);
        drive(1'b1, 1'b0, 1'b1);
        check(out_bit, 1'b0);
        drive(1'b1, 1'b0, 1'b0);
        check(out_bit, 1'b0);
        drive(1'b0, 1'b0, 1'b0);
        $display("test force done");
    endtask

    task automatic t_both();
        // default mode from an output already high
        precedence_select = TSRL_PREC_DEFAULT;
        drive(1'b0, 1'b1, 1'b0);
        drive(1'b0, 1'b1, 1'b1);
        check(out_bit, 1'b0);
        check(out_bit, 1'b0);
        precedence_select = TSRL_SET_FIRST;
        drive(1'b0, 1'b0, 1'b1);
        drive(1'b0, 1'b1, 1'b1);
        check(out_bit, 1'b1);
        drive(1'b0, 1'b0, 1'b0);
        check(out_bit, 1'b1);
        // reset in mid-run clears the output
        rst_n = 1'b0;
        @(negedge ref_clk);
        check(out_bit, 1'b0);
        rst_n = 1'b1;
        precedence_select = TSRL_PREC_DEFAULT;
        drive(1'b0, 1'b0, 1'b0);
        check(out_bit, 1'b0);
        $display("test precedence done");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        n_errors          = 0;
        check_count       = 0;
        rst_n             = 1'b0;
        toggle_trigger    = 1'b0;
        set_in            = 1'b0;
        reset_in          = 1'b0;
        precedence_select = TSRL_PREC_DEFAULT;
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        t_toggle();
        t_force();
        t_both();
        summarize();
    end

endmodule // toggle_set_reset_latch_bench
